// File: logic/ber_receiver_ctrl_and_memory_decode.v
// Function
// [RULE_01] one receiver and counter per stream 0-15
// [RULE_02] host writes zero to reserved control bits
// [RULE_03] clear bit holds counter at zero
// [RULE_04] start bit enables the stream's test
// [RULE_05] test result readable in count register
// [RULE_06] host drops start after test completes
// [RULE_07] host sets global enable before start
// [RULE_08] count register is read-only sixteen bits
// [RULE_09] counter saturates at maximum, never wraps
// [RULE_10] top address bit selects memory space
// [RULE_11] control bits 1-0 pick which memory
// [RULE_12] address 11-8 stream, 7-0 channel
// [RULE_13] 32 channels at 2M, 64 at 4M
// [RULE_14] 128 channels at 8M, 256 at 16M
// [RULE_15] each mismatched bit adds one to counter
`timescale 1ns/1ns
`include "ber_map.vh"
module ber_receiver_ctrl_and_memory_decode #(
  parameter STREAMS = 16,
  parameter DATA_W = 16,
  parameter CNT_W = 16
) (
  input wire clk,
  input wire rst_b,
  input wire host_cs,
  input wire host_rd,
  input wire host_wr,
  input wire [13:0] host_addr,
  input wire [DATA_W-1:0] host_wdata,
  output reg [DATA_W-1:0] host_rdata_q,
  output reg host_ack_q,
  input wire [STREAMS-1:0] rx_bit,
  input wire [STREAMS-1:0] rx_bit_valid,
  input wire [STREAMS-1:0] expected_bit,
  output wire [STREAMS-1:0] ber_test_active,
  output wire [1:0] mem_select
);
  // channel limit by stream rate
  function chan_ok;
    input [1:0] rate;
    input [7:0] chan;
    begin
      case (rate)
        `RATE_2M: chan_ok = (chan[7:5] == 3'h0); // [RULE_13]
        `RATE_4M: chan_ok = (chan[7:6] == 2'h0); // [RULE_13]
        `RATE_8M: chan_ok = (chan[7] == 1'b0); // [RULE_14]
        `RATE_16M: chan_ok = 1'b1; // [RULE_14]
        default: chan_ok = 1'b0;
      endcase
    end
  endfunction

  // register banks are sixteen words wide; the low four address bits pick the stream
  function bank_hit;
    input [13:0] addr;
    input [13:0] base;
    begin
      bank_hit = ((addr & `BANK_MASK) == base);
    end
  endfunction

  // read source for the memory space; code 3 selects nothing and reads zero
  function [DATA_W-1:0] mem_pick;
    input [1:0] sel;
    input [DATA_W-1:0] dm;
    input [DATA_W-1:0] cml;
    input [DATA_W-1:0] cmh;
    begin
      case (sel)
        `SEL_DATA_MEM: mem_pick = dm;
        `SEL_CONN_LOW: mem_pick = cml;
        `SEL_CONN_HIGH: mem_pick = cmh;
        default: mem_pick = {DATA_W{1'b0}};
      endcase
    end
  endfunction

  wire wr_req = host_cs & host_wr;
  wire rd_req = host_cs & host_rd & ~host_wr;
  wire [3:0] idx = host_addr[3:0];
  wire mem_space = host_addr[`MEM_SPACE_BIT]; // [RULE_10]
  wire [3:0] mem_stream = host_addr[11:8]; // [RULE_12]
  wire [7:0] mem_chan = host_addr[7:0]; // [RULE_12]
  wire in_ctrl = (host_addr == `CTRL_REG_ADDR);
  wire in_mode = (host_addr == `MODE_SEL_ADDR);
  wire in_rate = bank_hit(host_addr, `RATE_BASE);
  wire in_berc = bank_hit(host_addr, `BER_CTRL_BASE);
  wire in_cnt = bank_hit(host_addr, `BER_COUNT_BASE);

  reg [1:0] ctrl_q;
  reg global_en_q;
  wire [2*STREAMS-1:0] rate_q;
  wire [STREAMS-1:0] start_q;
  wire [STREAMS-1:0] clear_q;
  wire [CNT_W*STREAMS-1:0] count_flat;

  assign mem_select = ctrl_q;

  wire [1:0] cur_rate = rate_q[2*mem_stream +: 2];
  // bit 12 must be zero for a valid memory location
  wire mem_row_ok = ~host_addr[`MEM_ZERO_BIT]; // [RULE_12]
  // a channel past the stream's rate limit has no slot in the frame
  wire mem_chan_ok = chan_ok(cur_rate, mem_chan); // [RULE_13]
  wire mem_hit = mem_space & mem_row_ok & mem_chan_ok; // [RULE_10]

  wire reg_wr = wr_req & ~mem_space;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `CTRL_RESET;
    end else if (reg_wr && in_ctrl) begin
      ctrl_q <= host_wdata[1:0]; // [RULE_11]
    end
  end

  // the global enable only gates counting; a start without it is harmless
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      global_en_q <= 1'b0;
    end else if (reg_wr && in_mode) begin
      global_en_q <= host_wdata[`GLOBAL_RX_EN_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < STREAMS; g = g + 1) begin : stream_g
      reg [CNT_W-1:0] cnt_q;
      reg [CNT_W-1:0] cnt_d;
      reg start_bit_q;
      reg clear_bit_q;
      reg [1:0] rate_code_q;
      wire hit = reg_wr && (idx == g);
      wire err = rx_bit_valid[g] & (rx_bit[g] ^ expected_bit[g]);
      wire at_max = (cnt_q == `COUNT_MAX);

      // reserved bits 15-2 are dropped and read back as zero
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          start_bit_q <= 1'b0;
        end else if (hit && in_berc) begin
          start_bit_q <= host_wdata[`BER_START_BIT]; // [RULE_02]
        end
      end

      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          clear_bit_q <= 1'b0;
        end else if (hit && in_berc) begin
          clear_bit_q <= host_wdata[`BER_CLEAR_BIT]; // [RULE_03]
        end
      end

      // the rate only bounds host channel numbers; counting ignores it
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          rate_code_q <= `RATE_RESET;
        end else if (hit && in_rate) begin
          rate_code_q <= host_wdata[1:0]; // [RULE_13]
        end
      end

      assign start_q[g] = start_bit_q;
      assign clear_q[g] = clear_bit_q;
      assign rate_q[2*g +: 2] = rate_code_q;

      // the global enable gates start so a forgotten enable cannot count stray bits
      assign ber_test_active[g] = start_q[g] & global_en_q & ~clear_q[g]; // [RULE_04]

      always @* begin
        cnt_d = cnt_q;
        // clear is tested first so it holds zero even during an error burst
        if (clear_q[g]) begin
          cnt_d = {CNT_W{1'b0}}; // [RULE_03]
        end else if (ber_test_active[g] && err) begin
          if (!at_max) begin // [RULE_09]
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE_15]
          end
        end
      end

      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cnt_q <= {CNT_W{1'b0}};
        end else begin
          cnt_q <= cnt_d; // [RULE_01]
        end
      end

      assign count_flat[CNT_W*g +: CNT_W] = cnt_q; // [RULE_05]
    end
  endgenerate

  // memory port: data memory is read-only from the host
  wire [11:0] ram_addr = {mem_stream, mem_chan};
  wire mem_wr = wr_req & mem_hit;
  wire cml_we = mem_wr & (ctrl_q == `SEL_CONN_LOW);
  wire cmh_we = mem_wr & (ctrl_q == `SEL_CONN_HIGH);
  wire [DATA_W-1:0] dm_q;
  wire [DATA_W-1:0] cml_q;
  wire [DATA_W-1:0] cmh_q;

  word_ram #(.WIDTH(DATA_W), .ADDR_W(12)) data_mem (
    .clk(clk),
    .rst_b(rst_b),
    .we(1'b0),
    .addr(ram_addr),
    .wdata(host_wdata),
    .rdata_q(dm_q)
  );

  word_ram #(.WIDTH(DATA_W), .ADDR_W(12)) conn_low_mem (
    .clk(clk),
    .rst_b(rst_b),
    .we(cml_we), // [RULE_11]
    .addr(ram_addr),
    .wdata(host_wdata),
    .rdata_q(cml_q)
  );

  word_ram #(.WIDTH(DATA_W), .ADDR_W(12)) conn_high_mem (
    .clk(clk),
    .rst_b(rst_b),
    .we(cmh_we), // [RULE_11]
    .addr(ram_addr),
    .wdata(host_wdata),
    .rdata_q(cmh_q)
  );

  // read pipeline: stage 1 captures register data and the ram read starts,
  // stage 2 picks the source; both spaces answer two cycles after the request
  reg busy_q;
  reg rd_mem_q;
  reg [1:0] rd_sel_q;
  reg [DATA_W-1:0] reg_data_q;
  reg [DATA_W-1:0] reg_data_d;

  always @* begin
    reg_data_d = {DATA_W{1'b0}};
    if (in_ctrl) begin
      reg_data_d[1:0] = ctrl_q;
    end else if (in_mode) begin
      reg_data_d[`GLOBAL_RX_EN_BIT] = global_en_q;
    end else if (in_rate) begin
      reg_data_d[1:0] = rate_q[2*idx +: 2];
    end else if (in_berc) begin
      reg_data_d[`BER_START_BIT] = start_q[idx];
      reg_data_d[`BER_CLEAR_BIT] = clear_q[idx];
    end else if (in_cnt) begin
      reg_data_d[CNT_W-1:0] = count_flat[CNT_W*idx +: CNT_W]; // [RULE_08]
    end
  end

  // request tracking: the ack rises one clock after the edge that takes the request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= rd_req | wr_req;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_ack_q <= 1'b0;
    end else begin
      host_ack_q <= busy_q;
    end
  end

  // the select is taken with the request so a later control write cannot
  // steer a read that is already in flight
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_mem_q <= 1'b0;
      rd_sel_q <= 2'h3;
    end else begin
      rd_mem_q <= rd_req & mem_hit;
      rd_sel_q <= ctrl_q; // [RULE_11]
    end
  end

  // the count bank has no write path at all, so it stays read-only
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_data_q <= {DATA_W{1'b0}};
    end else begin
      reg_data_q <= mem_space ? {DATA_W{1'b0}} : reg_data_d; // [RULE_10]
    end
  end

  // write acks also load this path, so the host ignores data on them
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_q <= {DATA_W{1'b0}};
    end else if (busy_q) begin
      if (rd_mem_q) begin
        host_rdata_q <= mem_pick(rd_sel_q, dm_q, cml_q, cmh_q); // [RULE_11]
      end else begin
        host_rdata_q <= reg_data_q;
      end
    end
  end
endmodule

// File: logic/ber_map.vh
`ifndef BER_MAP_VH
`define BER_MAP_VH

// register space (word addresses on the host address bus)
`define CTRL_REG_ADDR 14'h0000
`define MODE_SEL_ADDR 14'h0001
`define RATE_BASE 14'h0340
`define BER_CTRL_BASE 14'h0350
`define BER_COUNT_BASE 14'h0360
`define BANK_MASK 14'h3FF0

// field positions
`define BER_START_BIT 0
`define BER_CLEAR_BIT 1
`define GLOBAL_RX_EN_BIT 0
`define MEM_SPACE_BIT 13
`define MEM_ZERO_BIT 12

// memory select codes in the control register
`define SEL_DATA_MEM 2'h0
`define SEL_CONN_LOW 2'h1
`define SEL_CONN_HIGH 2'h2

// stream rate codes
`define RATE_2M 2'h0
`define RATE_4M 2'h1
`define RATE_8M 2'h2
`define RATE_16M 2'h3

// reset values and limits
`define CTRL_RESET 2'h0
`define BER_CTRL_RESET 2'h0
`define RATE_RESET 2'h0
`define COUNT_MAX 16'hFFFF

`endif

// File: logic/word_ram.v
`timescale 1ns/1ns
module word_ram #(
  parameter WIDTH = 16,
  parameter ADDR_W = 12
) (
  input wire clk,
  input wire rst_b,
  input wire we,
  input wire [ADDR_W-1:0] addr,
  input wire [WIDTH-1:0] wdata,
  output reg [WIDTH-1:0] rdata_q
);
  reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read-before-write: a read to the written word returns the old contents
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= {WIDTH{1'b0}};
    end else begin
      rdata_q <= mem[addr];
    end
  end
endmodule

// File: verification/ber_decode_props.sv
`timescale 1ns/1ns
module ber_decode_props #(
  parameter STREAMS = 16,
  parameter DATA_W = 16
) (
  input wire clk,
  input wire rst_b,
  input wire host_cs,
  input wire host_rd,
  input wire host_wr,
  input wire [13:0] host_addr,
  input wire [DATA_W-1:0] host_wdata,
  input wire [DATA_W-1:0] host_rdata_q,
  input wire host_ack_q,
  input wire [STREAMS-1:0] ber_test_active,
  input wire [1:0] mem_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire req = host_cs && (host_rd || host_wr);
  wire rd_only = host_cs && host_rd && !host_wr;
  wire any_wr = host_cs && host_wr;
  wire ctrl_wr = host_cs && host_wr && host_addr == 14'h0000;
  wire bit12_rd = rd_only && host_addr[13:12] == 2'b11;
  wire berc_rd = rd_only && host_addr[13:4] == 10'h035;
  a_ack_after_two: assert property (req |-> ##2 host_ack_q)
    else $error("no ack two cycles after request");
  a_ack_has_cause: assert property (host_ack_q |-> $past(req, 2))
    else $error("ack without request");
  a_sel_follows: assert property (ctrl_wr |=> mem_select == $past(host_wdata[1:0]))
    else $error("memory select not loaded");
  a_sel_held: assert property (!ctrl_wr |=> $stable(mem_select))
    else $error("memory select changed without write");
  a_bit12_zero: assert property (bit12_rd |-> ##2 host_rdata_q == 16'h0000)
    else $error("bit 12 memory read not zero");
  a_ctrl_reserved: assert property (berc_rd |-> ##2 host_rdata_q[15:2] == 14'h0000)
    else $error("reserved control bits read nonzero");
  a_rdata_holds: assert property ($changed(host_rdata_q) |-> host_ack_q)
    else $error("read data moved without ack");
  a_active_cause: assert property ($changed(ber_test_active) |-> $past(any_wr))
    else $error("test enable moved without write");
  c_write: cover property (req && host_wr);
  c_ctrl: cover property (ctrl_wr);
  c_active: cover property (|ber_test_active);
  c_bit12: cover property (bit12_rd);
endmodule

// File: verification/host_model.sv
`timescale 1ns/1ns
module host_model (
  input wire clk,
  input wire host_ack_q,
  input wire [15:0] host_rdata_q,
  output reg host_cs,
  output reg host_rd,
  output reg host_wr,
  output reg [13:0] host_addr,
  output reg [15:0] host_wdata
);
  integer k;
  initial begin
    {host_cs, host_rd, host_wr, host_addr, host_wdata} = 33'h0;
  end
  // released address and data lines are inverted and the strobes drop to zero, so a stale value is never mistaken for a held one
  task xfer(input w, input [13:0] a, input [15:0] v, output [15:0] r, output ok);
    begin
      ok = 1'b0;
      @(negedge clk);
      {host_cs, host_wr, host_rd, host_addr, host_wdata} = {1'b1, w, ~w, a, v};
      @(negedge clk);
      {host_cs, host_wr, host_rd, host_addr, host_wdata} = {3'h0, ~a, ~v};
      for (k = 0; k < 4 && !ok; k = k + 1) begin
        @(negedge clk);
        if (host_ack_q === 1'b1) begin
          ok = 1'b1;
          r = host_rdata_q;
        end
      end
    end
  endtask
endmodule

// File: verification/ber_receiver_ctrl_and_memory_decode_bench.sv
`timescale 1ns/1ns
`include "ber_map.vh"
module ber_receiver_ctrl_and_memory_decode_bench;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [15:0] rx_bit = 16'h0000;
  reg [15:0] rx_bit_valid = 16'h0000;
  reg [15:0] expected_bit = 16'h0000;
  wire cs, rd_s, wr_s, ack;
  wire [13:0] addr;
  wire [15:0] wdata, rdata, active;
  wire [1:0] sel;
  integer miscompares = 0, tests_run = 0, seed = 49, i, j, s, n;
  reg [15:0] c, v, r;
  reg [13:0] a;
  reg ok;
  always #2 clk = ~clk;
  ber_receiver_ctrl_and_memory_decode dut_u (.clk(clk), .rst_b(rst_b), .host_cs(cs),
    .host_rd(rd_s), .host_wr(wr_s), .host_addr(addr), .host_wdata(wdata),
    .host_rdata_q(rdata), .host_ack_q(ack), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
    .expected_bit(expected_bit), .ber_test_active(active), .mem_select(sel));
  host_model host_u (.clk(clk), .host_ack_q(ack), .host_rdata_q(rdata), .host_cs(cs),
    .host_rd(rd_s), .host_wr(wr_s), .host_addr(addr), .host_wdata(wdata));
  function [15:0] sat(input [15:0] x, input e);
    sat = (x == `COUNT_MAX) ? x : x + e;
  endfunction
  function [15:0] exp_mem(input integer rt, input integer ch, input [15:0] x);
    exp_mem = (ch < (32 << rt)) ? x : 16'h0000;
  endfunction
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task acc(input w, input [13:0] ad, input [15:0] x);
    begin
      host_u.xfer(w, ad, x, r, ok);
      if (!ok) begin
        miscompares = miscompares + 1;
        report_and_stop;
      end
    end
  endtask
  task rdc(input [13:0] ad, input [15:0] e);
    begin
      acc(1'b0, ad, 16'h0000);
      chk(r, e);
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    s = $random(seed) & 15;
    acc(1'b1, `MODE_SEL_ADDR, 16'h0001);
    acc(1'b1, `BER_CTRL_BASE + s, 16'h0001);
    rdc(`BER_CTRL_BASE + s, 16'h0001);
    chk(active, 16'h0001 << s);
    c = 16'h0000;
    for (i = 0; i < 300; i = i + 1) begin
      @(negedge clk);
      rx_bit = $random(seed);
      expected_bit = $random(seed);
      rx_bit_valid = $random(seed);
      c = sat(c, rx_bit_valid[s] & (rx_bit[s] ^ expected_bit[s]));
    end
    @(negedge clk);
    rx_bit_valid = 16'h0000;
    rdc(`BER_COUNT_BASE + s, c);
    rdc(`BER_COUNT_BASE + ((s + 1) & 15), 16'h0000);
    acc(1'b1, `BER_COUNT_BASE + s, ~c);
    rdc(`BER_COUNT_BASE + s, c);
    {rx_bit, expected_bit, rx_bit_valid} = {16'hFFFF, 16'h0000, 16'hFFFF};
    repeat (65540) @(negedge clk);
    rdc(`BER_COUNT_BASE + s, `COUNT_MAX);
    acc(1'b1, `BER_CTRL_BASE + s, 16'h0003);
    rdc(`BER_COUNT_BASE + s, 16'h0000);
    acc(1'b1, `BER_CTRL_BASE + s, 16'h0000);
    chk(active, 16'h0000);
    for (j = 1; j < 4; j = j + 1) begin
      acc(1'b1, `CTRL_REG_ADDR, j);
      chk({14'h0000, sel}, j);
      for (i = 0; i < 4; i = i + 1) begin
        acc(1'b1, `RATE_BASE + s, i);
        n = (32 << i) - 1 + (i < 3 && ($random(seed) & 1));
        a = 14'h2000 | (s << 8) | n[7:0];
        v = $random(seed);
        acc(1'b1, a, v);
        rdc(a, (j == 3) ? 16'h0000 : exp_mem(i, n, v));
        rdc(a | 14'h1000, 16'h0000);
      end
    end
    report_and_stop;
  end
endmodule
bind ber_receiver_ctrl_and_memory_decode ber_decode_props #(.STREAMS(STREAMS),
  .DATA_W(DATA_W)) props_u (.clk(clk), .rst_b(rst_b), .host_cs(host_cs),
  .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
  .host_rdata_q(host_rdata_q), .host_ack_q(host_ack_q),
  .ber_test_active(ber_test_active), .mem_select(mem_select));
